/* File: rtl/rmc_top.sv */
// Reset sequencer, mode select and clock distribution
//
// The address-and-strobe port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`include "rmc_params.svh"
module rmc_top
#(
	parameter int STRETCH = 66
)
(
	input wire logic clk,
	input wire logic rst,
	// Reset sources
	input wire logic por_in,
	input wire logic wdog_rst,
	input wire logic lvd_rst,
	input wire logic ilop_rst,
	input wire logic ilad_rst,
	// Open-drain reset pin
	input wire logic reset_pin_in,
	output logic reset_pin_out,
	output logic reset_pin_oe,
	// Debug mode pin
	input wire logic debug_mode_pin_in,
	output logic debug_mode_pin_out,
	output logic debug_mode_pin_oe,
	// Clock sources
	input wire logic clkgen_primary_out,
	input wire logic clkgen_local_debug_clk,
	input wire logic clkgen_ext_ref_clk,
	input wire logic clkgen_int_ref_clk,
	input wire logic clkgen_fixed_freq_clk,
	input wire logic low_power_osc_clk,
	input wire logic timer_ext_clk_in,
	input wire logic xosc_clk,
	// Distributed clocks
	output logic bus_clk_a,
	output logic sys_clk,
	output logic watchdog_clk,
	output logic rtc_clk,
	output logic adc_alt_clk,
	output logic timer_clk,
	output logic debug_clk,
	// Mode and core status
	output logic sys_reset,
	output logic background_debug_state,
	output logic [15:0] fetch_addr,
	output logic port_dir_out,
	output logic port_pull_en,
	// Register port
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	output logic irq,
	// Debug link send request
	input wire logic link_start,
	input wire logic link_bit
);
	rmc_pkg::rmc_req_t req;
	rmc_pkg::rmc_clksel_t sel_q, sel_d; // Clock selects
	rmc_pkg::rmc_mode_t mode_q, mode_d; // Operating mode
	logic [6:0] cnt_q, cnt_d; // Stretch counter
	logic [`RMC_NCAUSE-1:0] cause_q, cause_d; // Sticky causes
	logic [`RMC_NCAUSE-1:0] mask_q, mask_d; // Interrupt mask
	logic [`RMC_NCAUSE-1:0] ev; // Causes this cycle
	logic frc_q, frc_d; // Debug force reset pending
	logic mode_samp_q, mode_samp_d; // Reset was mode-selecting
	logic pin_low; // Outside party holds pin low
	logic bus_tick;
	logic [7:0] rd_d, rd_q;
	logic irq_d, irq_q;
	logic rst_d, rst_q;
	logic bkgd_q;
	logic low_o, high_o, lbusy;
	logic [6:0] cyc_lim;
	logic [6:0] clk_q, clk_d;
	assign cyc_lim = 7'(STRETCH);
	assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr,
		rd: reg_rd};
	// Pin low while we are not driving it means an outside reset
	assign pin_low = !reset_pin_in && !reset_pin_oe;
	// Bus rate divider
	rmc_bus_div u_div
	(
		.clk(clk),
		.rst(rst),
		.bus_tick(bus_tick)
	);
	// Debug link bit driver
	rmc_link_tx u_link
	(
		.clk(clk),
		.rst(rst),
		.start(link_start && mode_q != rmc_pkg::RMC_ST_RESET),
		.bit_val(link_bit),
		.busy(lbusy),
		.drv_low(low_o),
		.drv_high(high_o)
	);
	// Gather every reset source into one event vector
	always_comb
	begin
		ev = '0;
		ev[`RMC_B_POR] = por_in;
		ev[`RMC_B_PIN] = pin_low && mode_q != rmc_pkg::RMC_ST_RESET;
		ev[`RMC_B_WDOG] = wdog_rst;
		ev[`RMC_B_LVD] = lvd_rst;
		ev[`RMC_B_ILOP] = ilop_rst;
		ev[`RMC_B_ILAD] = ilad_rst;
		ev[`RMC_B_DBG] = frc_q;
	end
	// Reset sequencing: stretch, cause record, mode decision
	always_comb
	begin
		cnt_d = cnt_q;
		mode_d = mode_q;
		mode_samp_d = mode_samp_q;
		frc_d = 1'b0;
		cause_d = cause_q;
		if (|ev)
		begin
			// A fresh reset replaces old causes with the new ones
			cause_d = ev;
			cnt_d = 7'h00;
			mode_d = rmc_pkg::RMC_ST_RESET;
			// Only power-on and forced resets select the mode
			mode_samp_d = ev[`RMC_B_POR] || ev[`RMC_B_DBG];
		end
		else if (mode_q == rmc_pkg::RMC_ST_RESET)
		begin
			// Count in bus cycles; pin must also be released
			if (bus_tick && cnt_q != cyc_lim)
				cnt_d = cnt_q + 7'h01;
			if (cnt_q == cyc_lim && reset_pin_in && bus_tick)
			begin
				// Release on a bus edge; pin resets never debug
				if (mode_samp_q && !debug_mode_pin_in)
					mode_d = rmc_pkg::RMC_ST_BKGD;
				else
					mode_d = rmc_pkg::RMC_ST_RUN;
			end
		end
		else
		begin
			// Status write-one-to-clear; new events already win
			if (req.wr && req.addr == `RMC_A_CAUSE)
				cause_d = cause_q & ~req.wdata[`RMC_NCAUSE-1:0];
			// Forced reset by writing the bit in run or debug state
			if (req.wr && req.addr == `RMC_A_FORCE && req.wdata[0])
				frc_d = 1'b1;
		end
	end
	// Sequencer registers
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			cnt_q <= 7'h00;
			mode_q <= rmc_pkg::RMC_ST_RESET;
			mode_samp_q <= 1'b1;
			frc_q <= 1'b0;
			cause_q <= 7'h01;
		end
		else
		begin
			cnt_q <= cnt_d;
			mode_q <= mode_d;
			mode_samp_q <= mode_samp_d;
			frc_q <= frc_d;
			cause_q <= cause_d;
		end
	end
	// Software registers: mask and clock selects
	always_comb
	begin
		mask_d = mask_q;
		sel_d = sel_q;
		if (mode_q == rmc_pkg::RMC_ST_RESET)
			sel_d = `RMC_CLKSEL_RST;
		else if (req.wr && req.addr == `RMC_A_MASK)
			mask_d = req.wdata[`RMC_NCAUSE-1:0];
		else if (req.wr && req.addr == `RMC_A_CLKSEL)
			sel_d = req.wdata;
	end
	// Mask and select registers
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			mask_q <= 7'h00;
			sel_q <= `RMC_CLKSEL_RST;
		end
		else
		begin
			mask_q <= mask_d;
			sel_q <= sel_d;
		end
	end
	// Read data one cycle after the strobe, zero elsewhere
	always_comb
	begin
		rd_d = 8'h00;
		if (req.rd)
		begin
			case (req.addr)
				`RMC_A_CAUSE: rd_d = {1'b0, cause_q};
				`RMC_A_MASK: rd_d = {1'b0, mask_q};
				`RMC_A_CLKSEL: rd_d = sel_q;
				`RMC_A_MODE: rd_d = {6'h00, mode_q};
				`RMC_A_VECTOR: rd_d = 8'(`RMC_VEC_ADDR >> 8);
				`RMC_A_LINK: rd_d = {7'h00, lbusy};
				default: rd_d = 8'h00;
			endcase
		end
		irq_d = |(cause_d & mask_d);
		rst_d = mode_d == rmc_pkg::RMC_ST_RESET;
	end
	// Clock routing: each output picks its documented sources
	always_comb
	begin
		clk_d[0] = sel_q.ext_osc ? xosc_clk : clkgen_primary_out;
		clk_d[1] = sel_q.wdog_lpo ? low_power_osc_clk : bus_tick;
		case (sel_q.rtc)
			2'h0: clk_d[2] = low_power_osc_clk;
			2'h1: clk_d[2] = clkgen_ext_ref_clk;
			2'h2: clk_d[2] = clkgen_int_ref_clk;
			default: clk_d[2] = low_power_osc_clk;
		endcase
		clk_d[3] = sel_q.adc_alt ? clkgen_ext_ref_clk : bus_tick;
		case (sel_q.tmr)
			2'h0: clk_d[4] = bus_tick;
			2'h1: clk_d[4] = clkgen_fixed_freq_clk;
			2'h2: clk_d[4] = timer_ext_clk_in;
			default: clk_d[4] = bus_tick;
		endcase
		clk_d[5] = sel_q.dbg_local ? clkgen_local_debug_clk
			: bus_tick;
		clk_d[6] = bus_tick;
	end
	// Output flops
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			rd_q <= 8'h00;
			irq_q <= 1'b0;
			rst_q <= 1'b1;
			clk_q <= 7'h00;
			bkgd_q <= 1'b0;
		end
		else
		begin
			rd_q <= rd_d;
			irq_q <= irq_d;
			rst_q <= rst_d;
			clk_q <= clk_d;
			bkgd_q <= mode_d == rmc_pkg::RMC_ST_BKGD;
		end
	end
	// Pin drive flops
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			reset_pin_oe <= 1'b1;
			debug_mode_pin_oe <= 1'b0;
			debug_mode_pin_out <= 1'b0;
		end
		else
		begin
			reset_pin_oe <= rst_d && cnt_d != cyc_lim;
			// During mode-select the pin is an input only
			debug_mode_pin_oe <= !rst_d && (low_o || high_o);
			debug_mode_pin_out <= high_o;
		end
	end
	assign reset_pin_out = 1'b0;
	assign reg_rdata = rd_q;
	assign irq = irq_q;
	assign sys_reset = rst_q;
	assign background_debug_state = bkgd_q;
	assign sys_clk = clk_q[0];
	assign watchdog_clk = clk_q[1];
	assign rtc_clk = clk_q[2];
	assign adc_alt_clk = clk_q[3];
	assign timer_clk = clk_q[4];
	assign debug_clk = clk_q[5];
	assign bus_clk_a = clk_q[6];
	assign fetch_addr = `RMC_VEC_ADDR;
	assign port_dir_out = 1'b0;
	assign port_pull_en = 1'b0;
endmodule

/* File: rtl/rmc_params.svh */
// Constants of the reset, mode-select and clock distribution block
// Summary of operation
// - Bus clock is primary clock divided by two
// - Internal clock selected after every reset
// - Low-power 1 kHz clock feeds watchdog and counter
// - Counter picks external or internal reference clock
// - Timers pick fixed clock or external pin
// - Local debug clock selectable for slow buses
// - Reset pin driven low 66 bus cycles
// - Each reset cause recorded in status register
// - Pin reset always enters user run mode
// - Mode pin sampled at power-on or forced reset
// - Mode pin high gives normal run mode
// - Mode pin low gives background debug state
// - Debug force-reset bit write forces reset
// - Each debug link bit spans 16 clocks
// - Link open-drain with brief driven-high pulses
// - Port pins reset to inputs, pull-ups off
// - Run mode starts at reset vector
`ifndef RMC_PARAMS_SVH
`define RMC_PARAMS_SVH
// Register offsets
`define RMC_A_CAUSE 4'h0
`define RMC_A_MASK 4'h1
`define RMC_A_CLKSEL 4'h2
`define RMC_A_FORCE 4'h3
`define RMC_A_MODE 4'h4
`define RMC_A_VECTOR 4'h5
`define RMC_A_LINK 4'h6
// Cause bit positions
`define RMC_B_POR 0
`define RMC_B_PIN 1
`define RMC_B_WDOG 2
`define RMC_B_LVD 3
`define RMC_B_ILOP 4
`define RMC_B_ILAD 5
`define RMC_B_DBG 6
`define RMC_NCAUSE 7
// Clock select field positions
`define RMC_F_WDOG 0
`define RMC_F_RTC_LO 1
`define RMC_F_TMR_LO 3
`define RMC_F_ADC 5
`define RMC_F_DBG 6
`define RMC_F_EXT 7
// Reset values and counts
`define RMC_CLKSEL_RST 8'h00
`define RMC_STRETCH_CYC 7'h42
`define RMC_BIT_CYC 5'h10
`define RMC_SPEEDUP_CYC 5'h01
`define RMC_ONE_LOW 5'h04
`define RMC_ZERO_LOW 5'h0D
`define RMC_VEC_ADDR 16'hFFFE
`endif

/* File: rtl/rmc_pkg.sv */
// Types shared by the reset and clock distribution block
package rmc_pkg;
	// Register port request
	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} rmc_req_t;
	// Mode chosen at reset release
	typedef enum logic [1:0] {
		RMC_ST_RESET = 2'h0,
		RMC_ST_RUN = 2'h1,
		RMC_ST_BKGD = 2'h2
	} rmc_mode_t;
	// Clock source selections
	typedef struct packed {
		logic ext_osc;
		logic dbg_local;
		logic adc_alt;
		logic [1:0] tmr;
		logic [1:0] rtc;
		logic wdog_lpo;
	} rmc_clksel_t;
endpackage

/* File: rtl/rmc_bus_div.sv */
// Bus clock enable derived from the primary clock
`timescale 1ns/1ps
module rmc_bus_div
(
	input wire logic clk,
	input wire logic rst,
	output logic bus_tick
);
	logic ph_q; // Phase of the divide-by-two
	logic ph_d;
	// Toggle every primary cycle
	always_comb
	begin
		ph_d = ~ph_q;
	end
	// Register the phase; reset starts on a fixed phase
	always_ff @(posedge clk)
	begin
		if (rst)
			ph_q <= 1'b0;
		else
			ph_q <= ph_d;
	end
	assign bus_tick = ph_q;
endmodule

/* File: rtl/rmc_link_tx.sv */
// Single-wire debug link bit driver, pseudo open-drain
`timescale 1ns/1ps
`include "rmc_params.svh"
module rmc_link_tx
(
	input wire logic clk,
	input wire logic rst,
	input wire logic start,
	input wire logic bit_val,
	output logic busy,
	output logic drv_low,
	output logic drv_high
);
	logic [4:0] cnt_q; // Cycle within the bit
	logic [4:0] cnt_d;
	logic val_q; // Bit being sent
	logic val_d;
	logic busy_q;
	logic busy_d;
	// Bit timing: low start, data, then a short driven-high speedup
	always_comb
	begin
		cnt_d = cnt_q;
		val_d = val_q;
		busy_d = busy_q;
		if (!busy_q && start)
		begin
			busy_d = 1'b1;
			cnt_d = 5'h00;
			val_d = bit_val;
		end
		else if (busy_q)
		begin
			if (cnt_q == `RMC_BIT_CYC - 5'h01)
				busy_d = 1'b0;
			cnt_d = cnt_q + 5'h01;
		end
	end
	// Register the bit state
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			cnt_q <= 5'h00;
			val_q <= 1'b0;
			busy_q <= 1'b0;
		end
		else
		begin
			cnt_q <= cnt_d;
			val_q <= val_d;
			busy_q <= busy_d;
		end
	end
	// A one releases after 4 cycles, a zero after 13
	assign drv_low = busy_q &&
		(cnt_q < (val_q ? `RMC_ONE_LOW : `RMC_ZERO_LOW));
	// Speedup pulse right after release, then float on the pull-up
	assign drv_high = busy_q &&
		(cnt_q >= (val_q ? `RMC_ONE_LOW : `RMC_ZERO_LOW)) &&
		(cnt_q < (val_q ? `RMC_ONE_LOW : `RMC_ZERO_LOW) +
		`RMC_SPEEDUP_CYC);
	assign busy = busy_q;
endmodule

/* File: sim/rmc_checker.sv */
// Assertion checker for the reset and clock distribution block
`timescale 1ns/1ps
module rmc_checker
#(
	parameter int STRETCH = 66
)
(
	input wire logic clk,
	input wire logic rst,
	input wire logic reset_pin_in,
	input wire logic reset_pin_oe,
	input wire logic debug_mode_pin_oe,
	input wire logic debug_mode_pin_out,
	input wire logic clkgen_primary_out,
	input wire logic sys_clk,
	input wire logic sys_reset,
	input wire logic [15:0] fetch_addr,
	input wire logic port_dir_out,
	input wire logic port_pull_en,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata
);
	// One domain, so clock and reset are stated once
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	chk_reset_drives_pin: assert property ($fell(rst) |-> reset_pin_oe && sys_reset)
		else $error("pin not driven after reset");
	chk_stretch_len: assert property ($rose(reset_pin_oe) |->
		reset_pin_oe[*6] ##[1:20] !reset_pin_oe)
		else $error("reset stretch length wrong");
	chk_release_pin_high: assert property ($fell(sys_reset) |->
		$past(reset_pin_in) && !reset_pin_oe)
		else $error("internal reset left while pin low");
	chk_fixed_outs: assert property (fetch_addr == 16'hFFFE &&
		!port_dir_out && !port_pull_en)
		else $error("vector or port defaults wrong");
	chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
		else $error("read data without read");
	chk_speedup_brief: assert property (debug_mode_pin_oe &&
		debug_mode_pin_out |=> !(debug_mode_pin_oe && debug_mode_pin_out))
		else $error("speed-up pulse too long");
	chk_link_low: assert property ($rose(debug_mode_pin_oe) |->
		(debug_mode_pin_oe && !debug_mode_pin_out)[*4])
		else $error("link bit low phase too short");
	chk_sys_internal: assert property (sys_reset |=>
		sys_clk == $past(clkgen_primary_out))
		else $error("system clock not internal");
endmodule
bind rmc_top rmc_checker #(.STRETCH(STRETCH)) u_chk (.clk, .rst,
	.reset_pin_in, .reset_pin_oe, .debug_mode_pin_oe, .debug_mode_pin_out,
	.clkgen_primary_out, .sys_clk, .sys_reset, .fetch_addr, .port_dir_out,
	.port_pull_en, .reg_rd, .reg_rdata);

/* File: sim/rmc_pod.sv */
// Reset switch and debug pod sitting on the two shared pins
`timescale 1ns/1ps
module rmc_pod
(
	input wire logic hold_reset,
	input wire logic hold_mode,
	input wire logic reset_pin_oe,
	input wire logic mode_oe,
	input wire logic mode_out,
	output logic reset_pin_in,
	output logic mode_in
);
	// Pull-up wins unless the switch or the device pulls low
	assign reset_pin_in = !(hold_reset || reset_pin_oe);
	// Device drive first, then the pod, then the pull-up
	assign mode_in = mode_oe ? mode_out : !hold_mode;
endmodule

/* File: sim/tb_rmc_top.sv */
// Self-checking bench for the reset and clock distribution block
`timescale 1ns/1ps
module tb_rmc_top;
	logic clk = 0;
	logic rst = 1;
	logic por_in = 0;
	logic [3:0] src = 4'h0; // Watchdog, voltage, opcode, address
	logic hold_reset = 0;
	logic hold_mode = 0;
	logic [3:0] reg_addr = 4'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 0;
	logic reg_rd = 0;
	logic link_start = 0;
	logic link_bit = 0;
	logic [7:0] ck = 8'h00; // Counter bits stand in for clock sources
	logic rp_in, rp_oe, m_in, m_out, m_oe, sys_reset, bkgd, irq;
	logic [7:0] reg_rdata;
	logic bclk; // Bus clock output as seen by the bench
	int err_total = 0;
	int total_checks = 0;
	always #50 clk = ~clk;
	always @(posedge clk) ck <= ck + 8'h01;
	rmc_top #(.STRETCH(4)) uut (.clk, .rst, .por_in, .wdog_rst(src[0]),
		.lvd_rst(src[1]), .ilop_rst(src[2]), .ilad_rst(src[3]),
		.reset_pin_in(rp_in), .reset_pin_out(), .reset_pin_oe(rp_oe),
		.debug_mode_pin_in(m_in), .debug_mode_pin_out(m_out),
		.debug_mode_pin_oe(m_oe), .clkgen_primary_out(ck[0]),
		.clkgen_local_debug_clk(ck[1]), .clkgen_ext_ref_clk(ck[2]),
		.clkgen_int_ref_clk(ck[3]), .clkgen_fixed_freq_clk(ck[4]),
		.low_power_osc_clk(ck[7]), .timer_ext_clk_in(ck[5]),
		.xosc_clk(ck[6]), .bus_clk_a(bclk), .sys_clk(), .watchdog_clk(),
		.rtc_clk(), .adc_alt_clk(), .timer_clk(), .debug_clk(), .sys_reset,
		.background_debug_state(bkgd), .fetch_addr(), .port_dir_out(),
		.port_pull_en(), .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .irq, .link_start, .link_bit);
	rmc_pod pod (.hold_reset, .hold_mode, .reset_pin_oe(rp_oe),
		.mode_oe(m_oe), .mode_out(m_out), .reset_pin_in(rp_in),
		.mode_in(m_in));
	// Compare one result
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			err_total++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// Register write, one cycle
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	// Register read, data stand one cycle later
	task automatic rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, e);
	endtask
	// Bounded wait for the internal reset to end
	task automatic settle;
		int i;
		repeat (3) @(posedge clk);
		for (i = 0; i < 300 && sys_reset !== 1'b0; i++)
			@(posedge clk);
		repeat (2) @(posedge clk);
	endtask
	// Send one link bit and count the driven-low cycles
	task automatic send(input logic b, input logic [7:0] e);
		int n;
		n = 0;
		@(posedge clk);
		link_start <= 1'b1;
		link_bit <= b;
		@(posedge clk);
		link_start <= 1'b0;
		repeat (20)
		begin
			@(posedge clk);
			#1 if (m_oe === 1'b1 && m_out === 1'b0) n++;
		end
		chk(8'(n), e);
	endtask
	task automatic wrap_up;
		$display("Checks %0d, errors %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// Main sequence
	initial
	begin
		int i;
		logic b0;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		settle();
		rd(4'h0, 8'h01);
		rd(4'h2, 8'h00);
		rd(4'hF, 8'h00);
		chk({7'h0, bkgd}, 8'h00);
		wr(4'h2, 8'h65);
		rd(4'h2, 8'h65);
		wr(4'h1, 8'h01);
		@(posedge clk);
		#1 chk({7'h0, irq}, 8'h01);
		wr(4'h0, 8'h01);
		@(posedge clk);
		#1 chk({7'h0, irq}, 8'h00);
		rd(4'h0, 8'h00);
		@(posedge clk);
		#1 b0 = bclk;
		@(posedge clk);
		#1 chk({7'h0, bclk}, {7'h0, ~b0});
		$display("Test registers done");
		for (i = 0; i < 4; i++)
		begin
			@(posedge clk);
			src <= 4'(1 << i);
			@(posedge clk);
			src <= 4'h0;
			settle();
			rd(4'h0, 8'(4 << i));
		end
		rd(4'h2, 8'h00);
		$display("Test sources done");
		hold_mode <= 1'b1;
		por_in <= 1'b1;
		@(posedge clk);
		por_in <= 1'b0;
		settle();
		chk({7'h0, bkgd}, 8'h01);
		rd(4'h4, 8'h02);
		hold_reset <= 1'b1;
		repeat (3) @(posedge clk);
		hold_reset <= 1'b0;
		settle();
		chk({7'h0, bkgd}, 8'h00);
		rd(4'h0, 8'h02);
		wr(4'h3, 8'h01);
		settle();
		chk({7'h0, bkgd}, 8'h01);
		rd(4'h0, 8'h40);
		hold_mode <= 1'b0;
		$display("Test modes done");
		send(1'b1, 8'h04);
		send(1'b0, 8'h0D);
		$display("Test link done");
		wrap_up();
	end
	// Watchdog against a hang
	initial
	begin
		#2000000;
		err_total++;
		wrap_up();
	end
endmodule
